// ### logic/rdsl_map.svh
// addresses, unlock codes, field positions and reset values of the security lock
`ifndef RDSL_MAP_SVH
`define RDSL_MAP_SVH
`define RDSL_DBG_SETTING_ADDR 32'hffffe510
`define RDSL_DBG_COMMIT_ADDR 32'hffffe514
`define RDSL_ROM_SETTING_ADDR 32'hffffe518
`define RDSL_ROM_COMMIT_ADDR 32'hffffe51c
`define RDSL_ROM_UNLOCK_CODE 32'h0000003d
`define RDSL_DBG_UNLOCK_CODE 32'h000000c5
`define RDSL_GUARD_BIT 0
`define RDSL_ROM_ON_RESET 1'b1
`define RDSL_DBG_OFF_RESET 1'b1
`define RDSL_BE_FULL 4'hf
`define RDSL_RESP_OKAY 2'h0
`define RDSL_RESP_SLVERR 2'h2
`define RDSL_ZERO_WORD 32'h00000000
`define RDSL_ZERO_UPPER 31'h00000000
`endif

// ### logic/rdsl_pkg.sv
// types shared by the security lock block
package rdsl_pkg;
  // avalon request from the cpu side
  typedef struct packed {
    logic read;
    logic write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } rdsl_avs_req_s;
  // avalon answer, both fields from flip-flops
  typedef struct packed {
    logic [31:0] readdata;
    logic [1:0] response;
  } rdsl_avs_rsp_s;
  // bus slave states
  typedef enum logic {
    RDSL_BUS_IDLE = 1'b0,
    RDSL_BUS_ACK = 1'b1
  } rdsl_bus_e;
  // decoded register select
  typedef enum logic [2:0] {
    RDSL_SEL_NONE = 3'b000,
    RDSL_SEL_DBG_SET = 3'b001,
    RDSL_SEL_DBG_COM = 3'b010,
    RDSL_SEL_ROM_SET = 3'b011,
    RDSL_SEL_ROM_COM = 3'b100
  } rdsl_sel_e;
endpackage

// ### logic/rdsl_lock.sv
// rom and debug security lock registers behind an avalon-mm slave
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "rdsl_map.svh"

module rdsl_lock
  import rdsl_pkg::*;
(
  // clock, resets and enable
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic i_clk_en,
  // avalon-mm slave
  input wire rdsl_avs_req_s i_avs_req,
  input wire logic i_fetch_from_rom,
  output logic o_avs_waitrequest,
  output rdsl_avs_rsp_s o_avs_rsp,
  // guard state towards rom, flash and debug unit
  input wire logic i_flash_protect,
  output logic o_rom_guard_on,
  output logic o_debug_probe_off,
  output logic o_rom_data_block,
  output logic o_debug_flash_block
);

  // maps a byte address to a register select
  function automatic rdsl_sel_e decode_addr(input logic [31:0] addr);
    rdsl_sel_e sel;
    case (addr)
      `RDSL_DBG_SETTING_ADDR: sel = RDSL_SEL_DBG_SET;
      `RDSL_DBG_COMMIT_ADDR: sel = RDSL_SEL_DBG_COM;
      `RDSL_ROM_SETTING_ADDR: sel = RDSL_SEL_ROM_SET;
      `RDSL_ROM_COMMIT_ADDR: sel = RDSL_SEL_ROM_COM;
      default: sel = RDSL_SEL_NONE;
    endcase
    return sel;
  endfunction

  // true for either of the two rom guard registers
  function automatic logic is_rom_sel(input rdsl_sel_e sel);
    return (sel == RDSL_SEL_ROM_SET) || (sel == RDSL_SEL_ROM_COM);
  endfunction

  rdsl_bus_e bus_state_reg;
  rdsl_avs_rsp_s rsp_reg;
  logic rom_pend_reg;
  logic rom_on_reg;
  logic dbg_pend_reg;
  logic dbg_off_reg;
  logic rom_block_reg;
  logic dbg_block_reg;
  rdsl_sel_e sel;
  logic req;
  logic full_word;
  logic blocked;
  logic allowed;
  logic wr_take;
  logic rom_code_ok;
  logic dbg_code_ok;

  // request decode and access permission
  assign req = i_avs_req.read | i_avs_req.write;
  assign sel = decode_addr(i_avs_req.address);
  assign full_word = (i_avs_req.byteenable == `RDSL_BE_FULL);
  assign blocked = rom_on_reg & ~i_fetch_from_rom & is_rom_sel(sel);
  assign allowed = (sel != RDSL_SEL_NONE) & full_word & ~blocked;
  assign wr_take = (bus_state_reg == RDSL_BUS_ACK) & i_avs_req.write & allowed & i_clk_en;
  assign rom_code_ok = (i_avs_req.writedata == `RDSL_ROM_UNLOCK_CODE);
  assign dbg_code_ok = (i_avs_req.writedata == `RDSL_DBG_UNLOCK_CODE);

  // one wait cycle per access, then the answer; a frozen slave keeps the master waiting so no write is lost
  assign o_avs_waitrequest = req & ((bus_state_reg != RDSL_BUS_ACK) | ~i_clk_en);

  // bus slave state, cleared by either reset
  always_ff @(posedge i_clk_sys or posedge i_reset or posedge i_por) begin
    if (i_reset || i_por) begin
      bus_state_reg <= RDSL_BUS_IDLE;
    end else if (i_clk_en) begin
      case (bus_state_reg)
        RDSL_BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= RDSL_BUS_ACK;
          end
        end
        RDSL_BUS_ACK: bus_state_reg <= RDSL_BUS_IDLE;
        default: bus_state_reg <= RDSL_BUS_IDLE;
      endcase
    end
  end

  // read data and response, latched one enabled edge before they are taken
  always_ff @(posedge i_clk_sys or posedge i_reset or posedge i_por) begin
    if (i_reset || i_por) begin
      rsp_reg.readdata <= `RDSL_ZERO_WORD;
      rsp_reg.response <= `RDSL_RESP_OKAY;
    end else if (i_clk_en && bus_state_reg == RDSL_BUS_IDLE && req) begin
      rsp_reg.readdata <= `RDSL_ZERO_WORD;
      rsp_reg.response <= allowed ? `RDSL_RESP_OKAY : `RDSL_RESP_SLVERR;
      if (i_avs_req.read && allowed) begin
        case (sel)
          RDSL_SEL_DBG_SET: rsp_reg.readdata <= {`RDSL_ZERO_UPPER, dbg_off_reg};
          RDSL_SEL_ROM_SET: rsp_reg.readdata <= {`RDSL_ZERO_UPPER, rom_on_reg};
          default: rsp_reg.readdata <= `RDSL_ZERO_WORD;
        endcase
      end
    end
  end

  assign o_avs_rsp = rsp_reg;

  // rom guard: pending value and active state, power-on reset only
  always_ff @(posedge i_clk_sys or posedge i_por) begin
    if (i_por) begin
      rom_pend_reg <= `RDSL_ROM_ON_RESET;
      rom_on_reg <= `RDSL_ROM_ON_RESET;
    end else if (wr_take) begin
      if (sel == RDSL_SEL_ROM_SET) begin
        rom_pend_reg <= i_avs_req.writedata[`RDSL_GUARD_BIT];
      end else if (sel == RDSL_SEL_ROM_COM && rom_code_ok) begin
        rom_on_reg <= rom_pend_reg;
      end
    end
  end

  // debug guard: pending value and active state, power-on reset only
  always_ff @(posedge i_clk_sys or posedge i_por) begin
    if (i_por) begin
      dbg_pend_reg <= `RDSL_DBG_OFF_RESET;
      dbg_off_reg <= `RDSL_DBG_OFF_RESET;
    end else if (wr_take) begin
      if (sel == RDSL_SEL_DBG_SET) begin
        dbg_pend_reg <= i_avs_req.writedata[`RDSL_GUARD_BIT];
      end else if (sel == RDSL_SEL_DBG_COM && dbg_code_ok) begin
        dbg_off_reg <= dbg_pend_reg;
      end
    end
  end

  // flash-secured blocking outputs
  always_ff @(posedge i_clk_sys or posedge i_por) begin
    if (i_por) begin
      rom_block_reg <= 1'b0;
      dbg_block_reg <= 1'b0;
    end else if (i_clk_en) begin
      rom_block_reg <= rom_on_reg & i_flash_protect;
      dbg_block_reg <= dbg_off_reg & i_flash_protect;
    end
  end

  assign o_rom_guard_on = rom_on_reg;
  assign o_debug_probe_off = dbg_off_reg;
  assign o_rom_data_block = rom_block_reg;
  assign o_debug_flash_block = dbg_block_reg;

  // an idle slave seeing a request
  sequence s_idle_req;
    (bus_state_reg == RDSL_BUS_IDLE) && req && i_clk_en;
  endsequence

  // an accepted write to a given register
  sequence s_wr(rdsl_sel_e s);
    wr_take && (sel == s);
  endsequence

  // a read request to a given register, seen by the idle slave
  sequence s_rd(rdsl_sel_e s);
    s_idle_req ##0 (i_avs_req.read && allowed && sel == s);
  endsequence

  // answer comes exactly one cycle after the request is seen
  AST_ONE_WAIT: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_idle_req |-> o_avs_waitrequest ##1 (bus_state_reg == RDSL_BUS_ACK))
    else $error("slave did not answer after one wait cycle");

  // correct rom code moves the pending value into the active state
  AST_ROM_COMMIT: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_wr(RDSL_SEL_ROM_COM) ##0 rom_code_ok |=> (rom_on_reg == $past(rom_pend_reg)))
    else $error("rom commit did not apply the pending value");

  // wrong rom code leaves the active rom state alone
  AST_ROM_BAD_CODE: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_wr(RDSL_SEL_ROM_COM) ##0 !rom_code_ok |=> $stable(rom_on_reg))
    else $error("wrong rom code changed the rom guard");

  // correct debug code moves the pending value into the active state
  AST_DBG_COMMIT: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_wr(RDSL_SEL_DBG_COM) ##0 dbg_code_ok |=> (dbg_off_reg == $past(dbg_pend_reg)))
    else $error("debug commit did not apply the pending value");

  // wrong debug code leaves the active debug state alone
  AST_DBG_BAD_CODE: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_wr(RDSL_SEL_DBG_COM) ##0 !dbg_code_ok |=> $stable(dbg_off_reg))
    else $error("wrong debug code changed the debug guard");

  // writing a setting alone never changes the active state
  AST_SET_ONLY_PENDING: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    (s_wr(RDSL_SEL_ROM_SET) or s_wr(RDSL_SEL_DBG_SET)) |=> $stable(rom_on_reg) && $stable(dbg_off_reg))
    else $error("setting write changed an active guard");

  // normal reset keeps every guard register
  AST_KEEP_ON_RESET: assert property (@(posedge i_clk_sys) disable iff (i_por)
    i_reset |=> $stable(rom_on_reg) && $stable(dbg_off_reg) && $stable(rom_pend_reg) && $stable(dbg_pend_reg))
    else $error("normal reset changed a guard register");

  // guarded rom registers ignore writes from outside the rom area
  AST_ROM_BLOCKED: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    (bus_state_reg == RDSL_BUS_ACK) && i_avs_req.write && is_rom_sel(sel) && rom_on_reg && !i_fetch_from_rom
    |=> $stable(rom_pend_reg) && $stable(rom_on_reg) && $past(o_avs_rsp.response) == `RDSL_RESP_SLVERR)
    else $error("blocked rom register access took effect");

  // debug setting reads show the active flag with upper bits zero
  AST_DBG_READ: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_rd(RDSL_SEL_DBG_SET) |=> (o_avs_rsp.readdata == {`RDSL_ZERO_UPPER, $past(dbg_off_reg)}))
    else $error("debug setting read wrong");

  // commit registers read as zero
  AST_COMMIT_READ: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    (s_rd(RDSL_SEL_ROM_COM) or s_rd(RDSL_SEL_DBG_COM)) |=> (o_avs_rsp.readdata == `RDSL_ZERO_WORD))
    else $error("commit register read not zero");

  // flash protection with an active guard blocks within one cycle
  AST_FLASH_BLOCK: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    i_clk_en && i_flash_protect && !i_por |=> (o_rom_data_block == $past(rom_on_reg))
    && (o_debug_flash_block == $past(dbg_off_reg)))
    else $error("flash-secured block output wrong");

  // without flash protection nothing is blocked
  AST_FLASH_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    i_clk_en && !i_flash_protect |=> !o_rom_data_block && !o_debug_flash_block)
    else $error("block output set without flash protection");

  // a partial word access is answered with an error
  AST_PART_WORD_ERR: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_idle_req ##0 !full_word |=> (o_avs_rsp.response == `RDSL_RESP_SLVERR))
    else $error("partial word access not refused");

  // a partial word write never reaches a guard register
  AST_PART_WORD_WR: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    (bus_state_reg == RDSL_BUS_ACK) && i_avs_req.write && !full_word
    |=> $stable(rom_pend_reg) && $stable(dbg_pend_reg) && $stable(rom_on_reg) && $stable(dbg_off_reg))
    else $error("partial word write changed a guard register");

  // rom setting reads show the active enable with upper bits zero
  AST_ROM_READ: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_rd(RDSL_SEL_ROM_SET) |=> (o_avs_rsp.readdata == {`RDSL_ZERO_UPPER, $past(rom_on_reg)}))
    else $error("rom setting read wrong");

  // a blocked rom register read returns zero with an error
  AST_ROM_BLOCKED_READ: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_idle_req ##0 (i_avs_req.read && is_rom_sel(sel) && rom_on_reg && !i_fetch_from_rom)
    |=> (o_avs_rsp.readdata == `RDSL_ZERO_WORD) && (o_avs_rsp.response == `RDSL_RESP_SLVERR))
    else $error("blocked rom register read not refused");

  // a rom setting write lands in the pending value
  AST_ROM_PENDING: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_wr(RDSL_SEL_ROM_SET) |=> (rom_pend_reg == $past(i_avs_req.writedata[`RDSL_GUARD_BIT])))
    else $error("rom setting write not held as pending");

  // a debug setting write lands in the pending value
  AST_DBG_PENDING: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_wr(RDSL_SEL_DBG_SET) |=> (dbg_pend_reg == $past(i_avs_req.writedata[`RDSL_GUARD_BIT])))
    else $error("debug setting write not held as pending");

  // permitted accesses, wrong unlock codes included, answer okay
  AST_RESP_OKAY: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_idle_req ##0 allowed |=> (o_avs_rsp.response == `RDSL_RESP_OKAY))
    else $error("permitted access not answered okay");

  // unmapped addresses read zero with an error
  AST_UNMAPPED: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    s_idle_req ##0 (sel == RDSL_SEL_NONE)
    |=> (o_avs_rsp.readdata == `RDSL_ZERO_WORD) && (o_avs_rsp.response == `RDSL_RESP_SLVERR))
    else $error("unmapped access not refused");

  // read data and response stand until the next request is latched
  AST_RSP_STANDS: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    !((bus_state_reg == RDSL_BUS_IDLE) && req && i_clk_en) |=> $stable(o_avs_rsp))
    else $error("answer changed without a new request");

  // the answer state lasts one enabled cycle
  AST_ACK_ONE_CYCLE: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    (bus_state_reg == RDSL_BUS_ACK) && i_clk_en |=> (bus_state_reg == RDSL_BUS_IDLE))
    else $error("slave stayed in the answer state");

  // a low clock enable keeps a pending request waiting
  AST_WAIT_FROZEN: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    req && !i_clk_en |-> o_avs_waitrequest)
    else $error("frozen slave released the master");

  // a low clock enable freezes every register
  AST_FREEZE: assert property (@(posedge i_clk_sys) disable iff (i_reset || i_por)
    !i_clk_en |=> $stable(bus_state_reg) && $stable(rsp_reg) && $stable(rom_pend_reg)
    && $stable(rom_on_reg) && $stable(dbg_pend_reg) && $stable(dbg_off_reg)
    && $stable(rom_block_reg) && $stable(dbg_block_reg))
    else $error("state changed while the clock enable was low");

endmodule

// ### testbench/rdsl_cpu_model.sv
// processor core model issuing avalon-mm register accesses
`timescale 1ns/10ps
module rdsl_cpu_model
  import rdsl_pkg::*;
(
  // clock and slave answer
  input wire logic i_clk_sys,
  input wire logic i_avs_waitrequest,
  input wire rdsl_avs_rsp_s i_avs_rsp,
  // request towards the slave
  output rdsl_avs_req_s o_avs_req,
  output logic o_fetch_from_rom
);
  // idle bus at time zero
  initial begin
    o_avs_req = '0;
    o_fetch_from_rom = 1'b0;
  end
  // one word transfer held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be, input logic f, output rdsl_avs_rsp_s r);
    @(posedge i_clk_sys);
    o_avs_req.read <= !wr;
    o_avs_req.write <= wr;
    o_avs_req.address <= a;
    o_avs_req.writedata <= d;
    o_avs_req.byteenable <= be;
    o_fetch_from_rom <= f;
    do begin
      @(posedge i_clk_sys);
    end while (i_avs_waitrequest);
    r = i_avs_rsp;
    // released strobes drop low; address, data, byte enables and fetch show the inverse of the last value
    o_avs_req <= '{1'b0, 1'b0, ~a, ~d, ~be};
    o_fetch_from_rom <= !f;
  endtask
endmodule

// ### testbench/rom_and_debug_security_lock_test.sv
// self-checking bench for the rom and debug security lock
`timescale 1ns/10ps
`include "rdsl_map.svh"
module rom_and_debug_security_lock_test
  import rdsl_pkg::*;
();
  logic i_clk_sys = 1'b0;
  logic clk_en = 1'b1;
  logic i_reset = 1'b1;
  logic i_por = 1'b1;
  logic flash = 1'b0;
  logic wait_req, fetch, rom_on, probe_off, rom_blk, dbg_blk;
  rdsl_avs_req_s req;
  rdsl_avs_rsp_s rsp, r;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 94;
  logic [31:0] d;
  // free-running system clock
  always #50 i_clk_sys = ~i_clk_sys;
  // design and cpu model
  rdsl_lock u_rdsl_lock (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_por(i_por), .i_clk_en(clk_en),
    .i_avs_req(req), .i_fetch_from_rom(fetch), .o_avs_waitrequest(wait_req), .o_avs_rsp(rsp),
    .i_flash_protect(flash), .o_rom_guard_on(rom_on), .o_debug_probe_off(probe_off),
    .o_rom_data_block(rom_blk), .o_debug_flash_block(dbg_blk));
  rdsl_cpu_model u_rdsl_cpu_model (.i_clk_sys(i_clk_sys), .i_avs_waitrequest(wait_req),
    .i_avs_rsp(rsp), .o_avs_req(req), .o_fetch_from_rom(fetch));
  // active state after a commit write
  function automatic logic nxt(logic cur, logic pend, logic [31:0] data, logic [31:0] code);
    return (data == code) ? pend : cur;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] dat, input logic f);
    u_rdsl_cpu_model.xfer(wr, a, dat, `RDSL_BE_FULL, f, r);
    // guard outputs settle after the accepting edge
    @(negedge i_clk_sys);
  endtask
  // read and compare data and response
  task automatic rdc(input logic [31:0] a, input logic f, input logic [31:0] ed, input logic [1:0] er);
    acc(1'b0, a, 32'h0, f);
    chk(r.readdata, ed);
    chk(32'(r.response), 32'(er));
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    miscompares++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    i_por <= 1'b0;
    rdc(`RDSL_DBG_SETTING_ADDR, 1'b0, 32'h1, `RDSL_RESP_OKAY);
    rdc(`RDSL_ROM_SETTING_ADDR, 1'b1, 32'h1, `RDSL_RESP_OKAY);
    rdc(`RDSL_DBG_COMMIT_ADDR, 1'b0, `RDSL_ZERO_WORD, `RDSL_RESP_OKAY);
    rdc(`RDSL_ROM_COMMIT_ADDR, 1'b1, `RDSL_ZERO_WORD, `RDSL_RESP_OKAY);
    $display("test power_on done");
    acc(1'b1, `RDSL_DBG_SETTING_ADDR, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d = (i == 0) ? 32'h000000c4 : d;
      acc(1'b1, `RDSL_DBG_COMMIT_ADDR, d, 1'b0);
      chk(32'(probe_off), 32'(nxt(1'b1, 1'b0, d, `RDSL_DBG_UNLOCK_CODE)));
    end
    // commit while the clock enable drops in the idle and the answer cycles
    @(posedge i_clk_sys);
    clk_en <= 1'b0;
    fork
      acc(1'b1, `RDSL_DBG_COMMIT_ADDR, `RDSL_DBG_UNLOCK_CODE, 1'b0);
      begin
        repeat (4) @(posedge i_clk_sys);
        clk_en <= 1'b1;
        @(posedge i_clk_sys);
        clk_en <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        clk_en <= 1'b1;
      end
    join
    chk(32'(probe_off), 32'h0);
    rdc(`RDSL_DBG_SETTING_ADDR, 1'b0, 32'h0, `RDSL_RESP_OKAY);
    acc(1'b1, `RDSL_DBG_SETTING_ADDR, 32'hffffffff, 1'b0);
    acc(1'b1, `RDSL_DBG_COMMIT_ADDR, `RDSL_DBG_UNLOCK_CODE, 1'b0);
    rdc(`RDSL_DBG_SETTING_ADDR, 1'b0, 32'h1, `RDSL_RESP_OKAY);
    $display("test debug_commit done");
    rdc(`RDSL_ROM_SETTING_ADDR, 1'b0, `RDSL_ZERO_WORD, `RDSL_RESP_SLVERR);
    acc(1'b1, `RDSL_ROM_SETTING_ADDR, 32'h0, 1'b0);
    acc(1'b1, `RDSL_ROM_COMMIT_ADDR, `RDSL_ROM_UNLOCK_CODE, 1'b0);
    chk(32'(rom_on), 32'h1);
    acc(1'b1, `RDSL_ROM_SETTING_ADDR, 32'h0, 1'b1);
    acc(1'b1, `RDSL_ROM_COMMIT_ADDR, `RDSL_ROM_UNLOCK_CODE, 1'b1);
    chk(32'(rom_on), 32'h0);
    rdc(`RDSL_ROM_SETTING_ADDR, 1'b0, 32'h0, `RDSL_RESP_OKAY);
    $display("test rom_commit done");
    acc(1'b1, `RDSL_DBG_SETTING_ADDR, 32'h0, 1'b0);
    u_rdsl_cpu_model.xfer(1'b1, `RDSL_DBG_COMMIT_ADDR, `RDSL_DBG_UNLOCK_CODE, 4'h3, 1'b0, r);
    @(negedge i_clk_sys);
    chk(32'(r.response), 32'(`RDSL_RESP_SLVERR));
    chk(32'(probe_off), 32'h1);
    rdc(32'hffffe520, 1'b0, `RDSL_ZERO_WORD, `RDSL_RESP_SLVERR);
    $display("test refused done");
    @(posedge i_clk_sys);
    flash <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    chk(32'({rom_blk, dbg_blk}), 32'h1);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    chk(32'({rom_on, probe_off}), 32'h1);
    i_por <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_por <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    chk(32'({rom_on, probe_off, rom_blk, dbg_blk}), 32'hf);
    $display("test resets done");
    final_report;
  end
endmodule
